/* logic/adc_cfg.svh */
/*
  Constants for the converter mode and calibration control block.
  Assumes it is included by bare name from the logic folder.
*/
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
// serial word lengths and bit counter width
`define WORD_BITS 5'h18
`define SHORT_BITS 5'h10
`define CNT_ZERO 5'h00
`define CNT_STEP 5'h01
// coefficient store: one zero and one full word per channel
`define CHAN_BITS 2
`define ADDR_BITS 3
`define DATA_BITS 24
// control word value after reset: normal mode, gain 1, first channel
`define CTL_RESET 24'h00_0000
// background calibration interleave: one conversion in six slots
`define BG_LAST_SLOT 3'h5
`define SLOT_ZERO 3'h0
`define SLOT_STEP 3'h1
// gain output is a one-hot power of two
`define GAIN_ONE 8'h01
`define TOP_BIT 23
`endif

/* logic/adc_pkg.sv */
/*
  Types for the converter mode and calibration control block.
  Assumes adc_cfg.svh holds the numeric constants.
*/
`default_nettype none
package adc_pkg;
  // operating mode field codes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_SELF_CAL = 3'h1,
    MODE_SYS_ZERO = 3'h2,
    MODE_SYS_FULL = 3'h3,
    MODE_SYS_OFFSET = 3'h4,
    MODE_BACKGROUND = 3'h5,
    MODE_ZERO_COEF = 3'h6,
    MODE_FULL_COEF = 3'h7
  } op_mode_type;

  // control word, most significant field first
  typedef struct packed {
    op_mode_type op_mode;
    logic [2:0] gain_code;
    logic channel_select_hi;
    logic channel_select_lo;
    logic word_length_sel;
    logic excitation_current_en;
    logic burnout_current_en;
    logic unipolar_sel;
    logic [11:0] notch_code;
  } control_word_type;

  // serial port pins as they arrive from outside
  typedef struct packed {
    logic serial_clock;
    logic write_frame_sync_n;
    logic read_frame_sync_n;
    logic register_select;
    logic serial_data_in;
  } serial_pins_type;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_WRITE = 2'h1,
    LINK_READ = 2'h2
  } link_state_type;
endpackage
`default_nettype wire

/* logic/pin_sync.sv */
/*
  Two-stage synchroniser for a group of pins.
  Assumes the pins are asynchronous to clock; only stage two is read.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  if (WIDTH < 1) begin : bad_width
    $error("pin_sync width must be positive");
  end

  ////////////////////////////////////////////////////////////////////
  // one pair of flops per pin; meta stage feeds nothing but stage two
  for (genvar i = 0; i < WIDTH; i++) begin : bit_sync
    logic meta;
    always_ff @(posedge clock) begin
      if (rst) begin
        meta <= 1'b1;
        synced[i] <= 1'b1;
      end else begin
        meta <= pins[i];
        synced[i] <= meta;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/coef_mem.sv */
/*
  Calibration coefficient store: zero and full words per channel.
  Assumes one writer per cycle; read data is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module coef_mem #(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 24
) (
  input wire logic clock,
  input wire logic write_en,
  input wire logic [ADDR_W-1:0] write_addr,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic [ADDR_W-1:0] read_addr,
  output logic [DATA_W-1:0] read_data
);
  if (ADDR_W < 1 || DATA_W < 1) begin : bad_shape
    $error("coef_mem needs positive address and data widths");
  end

  logic [DATA_W-1:0] store [2**ADDR_W];

  ////////////////////////////////////////////////////////////////////
  // contents are not reset, as in a plain ram
  always_ff @(posedge clock) begin
    if (write_en) begin
      store[write_addr] <= write_data;
    end
    read_data <= store[read_addr];
  end
endmodule
`default_nettype wire

/* logic/adc_mode_control.sv */
/*
  Control register, operating mode decode, calibration sequencing and
  the frame-synchronised serial port of a sigma-delta converter.
  Assumes a filter that pulses conv_valid with a new word and a
  calibration engine that pulses cal_done and writes coefficients.
  Serial pins are asynchronous and are sampled by clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
//
// Function
// - write frame with select low loads the control word
// - read frame with select low shifts out the control word
// - only a full 24-bit write frame or a calibration end changes the control word
// - serial clock pulses after the 24th are ignored
// - control word: mode, gain, channel, length, currents, polarity, notch
// - normal mode: select-high read returns conversion data
// - mode 001 self calibrates then clears mode, flags ready
// - mode 010 zero-scale system step then normal, flags ready
// - mode 011 full-scale system step then normal, flags ready
// - mode 100 system offset calibration then normal, flags ready
// - mode 101 interleaves calibration, one word in six
// - mode 110 select-high access reaches zero-scale coefficient
// - mode 111 select-high access reaches full-scale coefficient
// - coefficients move as 24-bit words; short writes discarded
// - ready falls on new word or calibration end, rises after read
module adc_mode_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic write_frame_sync_n,
  input wire logic read_frame_sync_n,
  input wire logic register_select,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic data_ready_n,
  input wire logic conv_valid,
  input wire logic [`TOP_BIT:0] conv_word,
  input wire logic cal_done,
  input wire logic cal_coef_we,
  input wire logic cal_coef_full,
  input wire logic [`TOP_BIT:0] cal_coef_word,
  output adc_pkg::control_word_type control_word,
  output logic [7:0] gain,
  output logic cal_start,
  output adc_pkg::op_mode_type cal_mode,
  output logic background_en,
  output logic [2:0] bg_slot
);
  adc_pkg::serial_pins_type pins_raw, pins;
  adc_pkg::link_state_type state, next_state;
  logic [4:0] bit_cnt, next_cnt, out_len, next_len;
  logic [`TOP_BIT:0] shift_in, next_sin, shift_out, next_sout;
  logic [`TOP_BIT:0] conv_hold, next_hold, mem_rdata, mem_wdata;
  logic [`TOP_BIT:0] next_mem_wdata;
  logic [2:0] mem_waddr, next_mem_waddr, mem_raddr, next_slot;
  logic mem_we, next_mem_we, data_frame, next_data_frame;
  logic next_dout, next_oe, read_done, ctl_load, coef_mode;
  logic sclk_d, tfs_d, rfs_d, sclk_rise, sclk_fall, tfs_fall, rfs_fall;
  logic cal_busy, next_busy, next_cal_start, next_ready_n, accept;
  logic next_bg;
  logic [7:0] next_gain;
  adc_pkg::control_word_type next_ctl;
  adc_pkg::op_mode_type next_cal_mode;

  assign pins_raw = '{serial_clock, write_frame_sync_n,
    read_frame_sync_n, register_select, serial_data_in};

  pin_sync #(.WIDTH($bits(adc_pkg::serial_pins_type))) sync_pins (
    .clock(clock),
    .rst(rst),
    .pins(pins_raw),
    .synced(pins)
  );

  ////////////////////////////////////////////////////////////////////
  // previous synced levels for edge finding
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_d <= 1'b1;
      tfs_d <= 1'b1;
      rfs_d <= 1'b1;
    end else begin
      sclk_d <= pins.serial_clock;
      tfs_d <= pins.write_frame_sync_n;
      rfs_d <= pins.read_frame_sync_n;
    end
  end

  assign sclk_rise = pins.serial_clock & ~sclk_d;
  assign sclk_fall = ~pins.serial_clock & sclk_d;
  assign tfs_fall = ~pins.write_frame_sync_n & tfs_d;
  assign rfs_fall = ~pins.read_frame_sync_n & rfs_d;
  assign coef_mode = (control_word.op_mode == adc_pkg::MODE_ZERO_COEF)
    || (control_word.op_mode == adc_pkg::MODE_FULL_COEF);
  // read address follows the mode, so data is ready before a frame
  assign mem_raddr = {control_word.op_mode == adc_pkg::MODE_FULL_COEF,
    control_word.channel_select_hi, control_word.channel_select_lo};

  coef_mem #(.ADDR_W(`ADDR_BITS), .DATA_W(`DATA_BITS)) coefs (
    .clock(clock),
    .write_en(mem_we),
    .write_addr(mem_waddr),
    .write_data(mem_wdata),
    .read_addr(mem_raddr),
    .read_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // serial link: frames, bit counting, shifting, store writes
  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_sin = shift_in;
    next_sout = shift_out;
    next_len = out_len;
    next_oe = serial_data_oe;
    next_data_frame = data_frame;
    next_mem_we = 1'b0;
    next_mem_waddr = mem_waddr;
    next_mem_wdata = mem_wdata;
    read_done = 1'b0;
    ctl_load = 1'b0;
    case (state)
      adc_pkg::LINK_IDLE: begin
        next_cnt = `CNT_ZERO;
        if (tfs_fall) begin
          next_state = adc_pkg::LINK_WRITE;
        end else if (rfs_fall) begin
          next_state = adc_pkg::LINK_READ;
          next_oe = 1'b1;
          next_len = `WORD_BITS;
          next_data_frame = 1'b0;
          if (!pins.register_select) begin
            next_sout = control_word;
          end else if (coef_mode) begin
            next_sout = mem_rdata;
          end else begin
            // conversion word, short form when length bit is clear
            next_sout = conv_hold;
            next_data_frame = 1'b1;
            if (!control_word.word_length_sel) begin
              next_len = `SHORT_BITS;
            end
          end
        end
      end
      adc_pkg::LINK_WRITE: begin
        // pulses past the full word are dropped
        if (sclk_rise && bit_cnt < `WORD_BITS) begin
          next_sin = {shift_in[`TOP_BIT-1:0], pins.serial_data_in};
          next_cnt = bit_cnt + `CNT_STEP;
        end
        if (pins.write_frame_sync_n) begin
          next_state = adc_pkg::LINK_IDLE;
          if (bit_cnt == `WORD_BITS) begin
            if (!pins.register_select) begin
              // full word into the control register
              ctl_load = 1'b1;
            end else if (coef_mode) begin
              next_mem_we = 1'b1;
              next_mem_waddr = mem_raddr;
              next_mem_wdata = shift_in;
            end
          end
        end
      end
      adc_pkg::LINK_READ: begin
        // data changes on falling clock, stable for the host's rise
        if (sclk_fall && bit_cnt < `WORD_BITS) begin
          next_sout = {shift_out[`TOP_BIT-1:0], 1'b0};
          next_cnt = bit_cnt + `CNT_STEP;
          // ready released once the whole word has gone out
          read_done = data_frame && (next_cnt == out_len);
        end
        if (pins.read_frame_sync_n) begin
          next_state = adc_pkg::LINK_IDLE;
          next_oe = 1'b0;
        end
      end
      default: begin
        next_state = adc_pkg::LINK_IDLE;
        next_oe = 1'b0;
      end
    endcase
    // engine results take the store when the serial port is not writing
    if (!next_mem_we && cal_coef_we) begin
      next_mem_we = 1'b1;
      next_mem_waddr = {cal_coef_full, control_word.channel_select_hi,
        control_word.channel_select_lo};
      next_mem_wdata = cal_coef_word;
    end
    next_dout = next_sout[`TOP_BIT];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= adc_pkg::LINK_IDLE;
      bit_cnt <= `CNT_ZERO;
      shift_in <= `CTL_RESET;
      shift_out <= `CTL_RESET;
      out_len <= `WORD_BITS;
      serial_data_oe <= 1'b0;
      serial_data_out <= 1'b0;
      data_frame <= 1'b0;
      mem_we <= 1'b0;
      mem_waddr <= `SLOT_ZERO;
      mem_wdata <= `CTL_RESET;
    end else begin
      state <= next_state;
      bit_cnt <= next_cnt;
      shift_in <= next_sin;
      shift_out <= next_sout;
      out_len <= next_len;
      serial_data_oe <= next_oe;
      serial_data_out <= next_dout;
      data_frame <= next_data_frame;
      mem_we <= next_mem_we;
      mem_waddr <= next_mem_waddr;
      mem_wdata <= next_mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control word, calibration start and completion
  always_comb begin
    next_ctl = control_word;
    next_busy = cal_busy;
    next_cal_start = 1'b0;
    next_cal_mode = cal_mode;
    if (ctl_load) begin
      // fields land in their packed positions
      next_ctl = shift_in;
      next_busy = 1'b0;
      // a calibration begins only from a loaded full word
      case (next_ctl.op_mode)
        adc_pkg::MODE_SELF_CAL, adc_pkg::MODE_SYS_ZERO,
        adc_pkg::MODE_SYS_FULL, adc_pkg::MODE_SYS_OFFSET: begin
          next_busy = 1'b1;
          next_cal_start = 1'b1;
          next_cal_mode = next_ctl.op_mode;
        end
        default: next_cal_mode = adc_pkg::MODE_NORMAL;
      endcase
    end else if (cal_busy && cal_done) begin
      // back to normal when the step ends
      next_ctl.op_mode = adc_pkg::MODE_NORMAL;
      next_busy = 1'b0;
    end
    next_gain = `GAIN_ONE << next_ctl.gain_code;
    next_bg = next_ctl.op_mode == adc_pkg::MODE_BACKGROUND;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      control_word <= `CTL_RESET;
      cal_busy <= 1'b0;
      cal_start <= 1'b0;
      cal_mode <= adc_pkg::MODE_NORMAL;
      gain <= `GAIN_ONE;
      background_en <= 1'b0;
    end else begin
      control_word <= next_ctl;
      cal_busy <= next_busy;
      cal_start <= next_cal_start;
      cal_mode <= next_cal_mode;
      gain <= next_gain;
      background_en <= next_bg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // conversion capture, background slots and the ready flag
  assign accept = conv_valid
    && ((control_word.op_mode == adc_pkg::MODE_NORMAL)
    || (background_en && bg_slot == `SLOT_ZERO));

  always_comb begin
    next_hold = conv_hold;
    next_slot = `SLOT_ZERO;
    // five of six slots measure reference and shorted inputs
    if (background_en) begin
      next_slot = bg_slot;
      if (conv_valid) begin
        next_slot = (bg_slot == `BG_LAST_SLOT) ? `SLOT_ZERO
          : bg_slot + `SLOT_STEP;
      end
    end
    // a word is not replaced while it is being shifted out
    if (accept && !(state == adc_pkg::LINK_READ && data_frame)) begin
      next_hold = conv_word;
    end
    // a new event wins over a release in the same cycle
    next_ready_n = data_ready_n;
    if (read_done) begin
      next_ready_n = 1'b1;
    end
    if (accept || (cal_busy && cal_done)) begin
      next_ready_n = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      conv_hold <= `CTL_RESET;
      bg_slot <= `SLOT_ZERO;
      data_ready_n <= 1'b1;
    end else begin
      conv_hold <= next_hold;
      bg_slot <= next_slot;
      data_ready_n <= next_ready_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_clk @(posedge clock); endclocking
  default disable iff (rst);

  chk_ctl_full_load: assert property (
    ctl_load |=> control_word == $past(shift_in))
    else $error("full write frame did not load control word");

  chk_short_frame: assert property (
    state == adc_pkg::LINK_WRITE && pins.write_frame_sync_n
    && bit_cnt != `WORD_BITS && !cal_done |=> $stable(control_word))
    else $error("short write frame changed control word");

  chk_count_cap: assert property (
    state == adc_pkg::LINK_WRITE && bit_cnt == `WORD_BITS
    |=> bit_cnt == `WORD_BITS && $stable(shift_in))
    else $error("clock pulse past the full word was taken");

  chk_ctl_readback: assert property (
    state == adc_pkg::LINK_IDLE && !tfs_fall && rfs_fall
    && !pins.register_select
    |=> shift_out == $past(control_word) && serial_data_oe)
    else $error("control readback not loaded");

  chk_cal_return: assert property (
    cal_busy && cal_done && !ctl_load
    |=> control_word.op_mode == adc_pkg::MODE_NORMAL && !data_ready_n)
    else $error("calibration end did not restore normal mode");

  chk_cal_pulse: assert property (
    cal_start |-> $past(ctl_load) ##1 !cal_start)
    else $error("calibration start not tied to a loaded word");

  chk_coef_write: assert property (
    ctl_load == 1'b0 && state == adc_pkg::LINK_WRITE
    && pins.write_frame_sync_n && pins.register_select && coef_mode
    && bit_cnt == `WORD_BITS |=> mem_we && mem_wdata == $past(shift_in))
    else $error("coefficient write lost");

  chk_ready_release: assert property (
    read_done && !accept && !(cal_busy && cal_done) |=> data_ready_n)
    else $error("ready not released after full word");

  // gain is registered on the same edge as the control word it follows
  chk_gain_hot: assert property (
    $onehot(gain) && gain[control_word.gain_code])
    else $error("gain does not follow the gain code");

  cov_self_cal: cover property (
    cal_start && cal_mode == adc_pkg::MODE_SELF_CAL ##[1:200] cal_done);
  cov_coef_write: cover property (mem_we && coef_mode);
  cov_data_read: cover property (read_done ##1 data_ready_n);
  cov_bg_wrap: cover property (background_en
    && bg_slot == `BG_LAST_SLOT && conv_valid);
endmodule
`default_nettype wire

/* tb/host_model.sv */
/*
  Host model for the converter serial port: frames, serial clock, data.
  Assumes the bench resolves the shared data wire and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sdata,
  output logic serial_clock,
  output logic write_frame_sync_n,
  output logic read_frame_sync_n,
  output logic register_select,
  output logic host_data
);
  localparam realtime HALF = 62.5;
  // idle pins: serial clock parked low outside frames, frames off
  initial begin
    serial_clock = 1'b0;
    write_frame_sync_n = 1'b1;
    read_frame_sync_n = 1'b1;
    register_select = 1'b0;
    host_data = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // one frame of n bits; write bits go msb first from w[27] downward
  task automatic frame(input logic sel, input logic wr, input int n, input logic [27:0] w,
      output logic [23:0] r);
    r = 24'h00_0000;
    register_select = sel;
    #20;
    if (wr) write_frame_sync_n = 1'b0;
    else read_frame_sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (wr) host_data = w[27-i];
      #HALF;
      serial_clock = 1'b1;
      if (!wr) r = {r[22:0], sdata};
      #HALF;
      serial_clock = 1'b0;
    end
    #HALF;
    write_frame_sync_n = 1'b1;
    read_frame_sync_n = 1'b1;
    #20;
    // released line shows the inverse so a stale copy cannot pass
    host_data = ~host_data;
    #300;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the converter mode and calibration control.
  Assumes host_model drives the serial port; events come from here.
*/
`timescale 1ns/1ps
`default_nettype none
`define check_eq(what, exp, act) \
  begin \
    total_checks++; \
    if ((act) !== (exp)) begin \
      n_fail++; \
      $display("unexpected %s expected %h seen %h", what, (exp), (act)); \
    end \
  end
module tb_top;
  logic clock, rst, conv_valid, cal_done, cal_coef_we, cal_coef_full;
  logic [23:0] conv_word, cal_coef_word, d;
  logic serial_clock, write_frame_sync_n, read_frame_sync_n, register_select;
  logic host_data, serial_data_in, serial_data_out, serial_data_oe;
  logic data_ready_n, cal_start, background_en;
  logic [7:0] gain;
  logic [2:0] bg_slot;
  adc_pkg::control_word_type control_word;
  adc_pkg::op_mode_type cal_mode;
  int n_fail = 0;
  int total_checks = 0;
  int n_starts = 0;
  int s0, hits;
  logic [23:0] last;

  adc_mode_control dut_u (.clock(clock), .rst(rst), .serial_clock(serial_clock),
    .write_frame_sync_n(write_frame_sync_n), .read_frame_sync_n(read_frame_sync_n),
    .register_select(register_select), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .data_ready_n(data_ready_n), .conv_valid(conv_valid), .conv_word(conv_word),
    .cal_done(cal_done), .cal_coef_we(cal_coef_we), .cal_coef_full(cal_coef_full),
    .cal_coef_word(cal_coef_word), .control_word(control_word), .gain(gain),
    .cal_start(cal_start), .cal_mode(cal_mode), .background_en(background_en),
    .bg_slot(bg_slot));
  host_model host_u (.sdata(serial_data_in), .serial_clock(serial_clock),
    .write_frame_sync_n(write_frame_sync_n), .read_frame_sync_n(read_frame_sync_n),
    .register_select(register_select), .host_data(host_data));

  // shared data wire: device wins while its enable is up
  assign serial_data_in = serial_data_oe ? serial_data_out : host_data;

  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // count calibration starts
  always @(posedge clock) begin
    if (cal_start === 1'b1) n_starts <= n_starts + 1;
  end

  //////////////////////////////////////////////////////////////////////
  // notch code kept at 19
  function automatic logic [23:0] ctl(input logic [2:0] m, input logic [2:0] g,
      input logic [1:0] ch, input logic wl);
    return {m, g, ch, wl, 3'h0, 12'h013};
  endfunction

  task automatic wr(input logic sel, input int n, input logic [27:0] w);
    logic [23:0] unused;
    host_u.frame(sel, 1'b1, n, w, unused);
    // realign so checks never land on a rising clock edge
    @(negedge clock);
  endtask

  task automatic wr24(input logic sel, input logic [23:0] w);
    wr(sel, 24, {w, 4'h0});
  endtask

  task automatic rd(input logic sel, input int n, output logic [23:0] r);
    host_u.frame(sel, 1'b0, n, 28'h000_0000, r);
    @(negedge clock);
  endtask

  // kind 0 conversion, 1 calibration end, 2 engine zero-scale, 3 full-scale write
  task automatic pulse(input int kind, input logic [23:0] w);
    @(negedge clock);
    conv_word = w;
    cal_coef_word = w;
    conv_valid = (kind == 0);
    cal_done = (kind == 1);
    cal_coef_we = (kind >= 2);
    cal_coef_full = (kind == 3);
    @(negedge clock);
    {conv_valid, cal_done, cal_coef_we, cal_coef_full} = 4'h0;
    @(negedge clock);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang is cut short here
  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    $display("unexpected timeout");
    summarize();
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    {conv_valid, cal_done, cal_coef_we, cal_coef_full} = 4'h0;
    conv_word = 24'h00_0000;
    cal_coef_word = 24'h00_0000;
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    `check_eq("control_word", 24'h00_0000, control_word)
    `check_eq("gain", 8'h01, gain)
    `check_eq("data_ready_n", 1'b1, data_ready_n)
    // every gain code, with readback of the whole word
    for (int g = 0; g < 8; g++) begin
      last = ctl(3'h0, 3'(g), 2'h2, 1'b1);
      wr24(1'b0, last);
      `check_eq("control_word", last, control_word)
      `check_eq("gain", 8'(1 << g), gain)
      rd(1'b0, 24, d);
      `check_eq("control readback", last, d)
      `check_eq("serial_data_oe", 1'b0, serial_data_oe)
    end
    // short frame carrying a calibration code changes nothing
    s0 = n_starts;
    wr(1'b0, 16, {ctl(3'h1, 3'h0, 2'h0, 1'b1), 4'h0});
    `check_eq("short write", last, control_word)
    `check_eq("starts", s0, n_starts)
    // pulses after the 24th are ignored
    last = ctl(3'h0, 3'h3, 2'h1, 1'b1);
    wr(1'b0, 28, {last, 4'hf});
    `check_eq("long write", last, control_word)
    // calibration modes 001 to 100
    for (int m = 1; m <= 4; m++) begin
      s0 = n_starts;
      wr24(1'b0, ctl(3'(m), 3'h0, 2'h1, 1'b1));
      `check_eq("starts", s0 + 1, n_starts)
      `check_eq("cal_mode", 3'(m), cal_mode)
      pulse(1, 24'h00_0000);
      `check_eq("data_ready_n", 1'b0, data_ready_n)
      `check_eq("mode field", adc_pkg::MODE_NORMAL, control_word.op_mode)
      rd(1'b1, 24, d);
      `check_eq("data_ready_n", 1'b1, data_ready_n)
    end
    // normal mode data reads, 24 then 16 bits
    wr24(1'b0, ctl(3'h0, 3'h0, 2'h0, 1'b1));
    pulse(0, 24'h5a_c3e1);
    `check_eq("data_ready_n", 1'b0, data_ready_n)
    rd(1'b1, 24, d);
    `check_eq("data word", 24'h5a_c3e1, d)
    `check_eq("data_ready_n", 1'b1, data_ready_n)
    wr24(1'b0, ctl(3'h0, 3'h0, 2'h0, 1'b0));
    pulse(0, 24'h9b_1234);
    rd(1'b1, 16, d);
    `check_eq("short data word", 16'h9b12, d[15:0])
    `check_eq("data_ready_n", 1'b1, data_ready_n)
    // coefficient access, short write refused, two stores kept apart
    wr24(1'b0, ctl(3'h6, 3'h0, 2'h1, 1'b0));
    wr24(1'b1, 24'ha1_b2c3);
    rd(1'b1, 24, d);
    `check_eq("zero coef", 24'ha1_b2c3, d)
    wr(1'b1, 16, 28'hfff_f000);
    rd(1'b1, 24, d);
    `check_eq("zero coef short", 24'ha1_b2c3, d)
    wr24(1'b0, ctl(3'h7, 3'h0, 2'h1, 1'b1));
    wr24(1'b1, 24'h3c_4d5e);
    rd(1'b1, 24, d);
    `check_eq("full coef", 24'h3c_4d5e, d)
    wr24(1'b0, ctl(3'h6, 3'h0, 2'h1, 1'b1));
    rd(1'b1, 24, d);
    `check_eq("zero coef kept", 24'ha1_b2c3, d)
    pulse(2, 24'h77_0011);
    rd(1'b1, 24, d);
    `check_eq("engine coef", 24'h77_0011, d)
    // engine full-scale result lands in the full store of the channel
    pulse(3, 24'h66_0022);
    wr24(1'b0, ctl(3'h7, 3'h0, 2'h1, 1'b1));
    rd(1'b1, 24, d);
    `check_eq("engine full coef", 24'h66_0022, d)
    // background: twelve words give exactly two kept
    wr24(1'b0, ctl(3'h5, 3'h2, 2'h0, 1'b1));
    `check_eq("background_en", 1'b1, background_en)
    hits = 0;
    for (int k = 0; k < 12; k++) begin
      pulse(0, 24'h12_3456);
      if (data_ready_n === 1'b0) begin
        hits++;
        rd(1'b1, 24, d);
      end
    end
    `check_eq("kept words", 2, hits)
    `check_eq("bg_slot", 3'h0, bg_slot)
    // reset in mid-run brings back normal mode and unity gain
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    `check_eq("reset control_word", 24'h00_0000, control_word)
    `check_eq("reset background_en", 1'b0, background_en)
    `check_eq("reset gain", 8'h01, gain)
    summarize();
  end
endmodule
`default_nettype wire
